// ### flash_timing_pkg.sv
// Shared timing constants, opcodes and state encoding for the flash operation sequencer
package flash_timing_pkg;

    // Core clock rate used to turn times into cycle counts
    localparam real CLK_MHZ = 100.0;

    // Longest time rounds down, never below one cycle
    function automatic int cyc_max(input real t_us);
        int c;
        c = int'($floor(t_us * CLK_MHZ));
        return (c < 1) ? 1 : c;
    endfunction : cyc_max

    // Least time rounds up
    function automatic int cyc_min(input real t_us);
        int c;
        c = int'($ceil(t_us * CLK_MHZ));
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    // Deep power-down entry and release recovery
    localparam real T_DP_US = 10.0;
    localparam real T_RDP_US = 45.0;
    localparam int DP_CYC = cyc_max(T_DP_US);
    localparam int RDP_CYC = cyc_max(T_RDP_US);

    // Suspend latency until the busy flag drops
    localparam real T_SUSP_US = 40.0;
    localparam int SUSP_CYC = cyc_max(T_SUSP_US);

    // Nominal run times of the internal operations (typical figures, all under the maxima)
    localparam real T_STW_MS = 9.5;
    localparam real T_BP_US = 30.0;
    localparam real T_PP_MS = 0.8;
    localparam real T_PP_HV_MS = 0.56;
    localparam real T_SE_MS = 38.0;
    localparam real T_SE_HV_MS = 34.0;
    localparam real T_BE32_S = 0.225;
    localparam real T_BE64_S = 0.45;
    localparam real T_CE_S = 12.0;
    localparam real T_CE_HV_S = 11.0;
    localparam int STW_CYC = cyc_max(T_STW_MS * 1000.0);
    localparam int BP_CYC = cyc_max(T_BP_US);
    localparam int PP_CYC = cyc_max(T_PP_MS * 1000.0);
    localparam int PP_HV_CYC = cyc_max(T_PP_HV_MS * 1000.0);
    localparam int SE_CYC = cyc_max(T_SE_MS * 1000.0);
    localparam int SE_HV_CYC = cyc_max(T_SE_HV_MS * 1000.0);
    localparam int BE32_CYC = cyc_max(T_BE32_S * 1000000.0);
    localparam int BE64_CYC = cyc_max(T_BE64_S * 1000000.0);
    localparam int CE_CYC = cyc_max(T_CE_S * 1000000.0);
    localparam int CE_HV_CYC = cyc_max(T_CE_HV_S * 1000000.0);

    // Recovery after a reset, by interrupted activity
    localparam real T_RR_DEC_US = 30.0;
    localparam real T_RR_PGM_US = 80.0;
    localparam real T_RR_ERS_MS = 12.0;
    localparam real T_RR_STW_MS = 0.1;
    localparam int RR_DEC_CYC = cyc_min(T_RR_DEC_US);
    localparam int RR_PGM_CYC = cyc_min(T_RR_PGM_US);
    localparam int RR_ERS_CYC = cyc_min(T_RR_ERS_MS * 1000.0);
    localparam int RR_STW_CYC = cyc_min(T_RR_STW_MS * 1000.0);

    // Link framing
    localparam int OP_BITS = 8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;

    // Opcodes (first byte of a frame)
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h11;
    localparam logic [7:0] CMD_BYTE_PROG = 8'h12;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h13;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h14;
    localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h15;
    localparam logic [7:0] CMD_BLOCK64_ERASE = 8'h16;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h17;
    localparam logic [7:0] CMD_SUSPEND = 8'h18;
    localparam logic [7:0] CMD_RESUME = 8'h19;
    localparam logic [7:0] CMD_DEEP_PD = 8'h1a;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h1b;
    localparam logic [7:0] CMD_NONE = 8'h00;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BUSY = 3'b001,
        ST_SUSPENDING = 3'b010,
        ST_SUSPENDED = 3'b011,
        ST_DPD_ENTER = 3'b100,
        ST_DPD = 3'b101,
        ST_DPD_RECOVER = 3'b110,
        ST_RST_RECOVER = 3'b111
    } seq_state_t;

endpackage : flash_timing_pkg

// ### level_sync.sv
// Two-stage synchroniser for a level entering the core clock domain
`timescale 1ns/10ps
module level_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : level_sync

// ### op_timer.sv
// Down counter that times one internal operation phase
`timescale 1ns/10ps
module op_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic [WIDTH-1:0] count,
    output logic expire
);
    logic [WIDTH-1:0] cnt_next;

    // Load wins; otherwise count down and rest at zero
    always_comb begin
        cnt_next = count;
        if (load) begin
            cnt_next = load_val;
        end else if (count != '0) begin
            cnt_next = count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= cnt_next;
        end
    end

    // Last cycle of the phase, so the phase lasts exactly load_val cycles
    assign expire = (count == WIDTH'(1));
endmodule : op_timer

// ### serial_flash_op_timing.sv
// Operation timing sequencer of a serial flash: power-down, suspend, reset recovery, busy
//
// Overview of operation
// RULE1: After select rises on power-down command, enter power-down within 10 us.
// RULE2: Host waits 30 us after power-down entry before releasing.
// RULE3: Host holds select low at least 20 ns to release power-down.
// RULE4: After release, device recovers up to 45 us; commands ignored meanwhile.
// RULE5: Status write finishes within 20 ms, typically 9.5 ms.
// RULE6: Host waits recovery time after reset, by interrupted activity.
// RULE7: Suspend completes within 40 us, busy flag zero at the end.
// RULE8: Host waits 0.3 us after resume before the next suspend.
// RULE9: Program progress needs resume-to-suspend intervals of 100 us.
// RULE10: Erase progress needs resume-to-suspend intervals of 280 us.
// RULE11: Erase and program suspend accepted as often as issued.
// RULE12: Byte program finishes within 100 us, typically 30 us.
// RULE13: Page program finishes within 4 ms, or 3.6 ms at high voltage.
// RULE14: Sector erase finishes within 240 ms, or 210 ms at high voltage.
// RULE15: 32 KB block erase finishes within 1.5 s, typically 0.225 s.
// RULE16: 64 KB block erase finishes within 3 s, typically 0.45 s.
// RULE17: Chip erase finishes within 38 s, or 34 s at high voltage.
// RULE18: Host keeps select high during power-up until supply and wait settle.
// RULE19: Busy flag is one during any timed operation, cleared on completion. The code keeps it low during power-down entry (ST_DPD_ENTER).
`timescale 1ns/10ps
module serial_flash_op_timing
    import flash_timing_pkg::*;
#(
    parameter int unsigned RDP_CYCLES = RDP_CYC,
    parameter int unsigned STW_CYCLES = STW_CYC,
    parameter int unsigned PP_CYCLES = PP_CYC,
    parameter int unsigned PP_HV_CYCLES = PP_HV_CYC,
    parameter int unsigned SE_CYCLES = SE_CYC,
    parameter int unsigned SE_HV_CYCLES = SE_HV_CYC,
    parameter int unsigned BE32_CYCLES = BE32_CYC,
    parameter int unsigned BE64_CYCLES = BE64_CYC,
    parameter int unsigned CE_CYCLES = CE_CYC,
    parameter int unsigned CE_HV_CYCLES = CE_HV_CYC,
    parameter int unsigned RR_PGM_CYCLES = RR_PGM_CYC,
    parameter int unsigned RR_ERS_CYCLES = RR_ERS_CYC,
    parameter int unsigned RR_STW_CYCLES = RR_STW_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_high_voltage,
    output logic busy_flag,
    output logic suspended_flag,
    output logic dpd_flag
);
    localparam int TW = 32;

    // Link side: bit counter and shifter, cleared by the frame's own select
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] op_hold_reg;
    logic [7:0] op_hold_next;
    logic op_tgl_reg;
    logic op_tgl_next;
    logic capture;

    // Core side
    logic cs_s;
    logic hv_s;
    logic tgl_s;
    logic cs_d1_reg;
    logic cs_d2_reg;
    logic tgl_seen_reg;
    logic tgl_seen_next;
    logic pend_reg;
    logic pend_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic cs_rise;
    logic cs_fall;
    logic cmd_go;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [7:0] kind_reg;
    logic [7:0] kind_next;
    logic [TW-1:0] remain_reg;
    logic [TW-1:0] remain_next;
    logic busy_next;
    logic susp_next;
    logic dpd_next;
    logic t_load;
    logic [TW-1:0] t_val;
    logic [TW-1:0] t_count;
    logic t_expire;

    // Run time of a program, erase or status write; high voltage shortens some
    function automatic logic [TW-1:0] op_cycles(input logic [7:0] op, input logic hv);
        case (op)
            CMD_STATUS_WRITE: op_cycles = TW'(STW_CYCLES); // [RULE5]
            CMD_BYTE_PROG: op_cycles = TW'(BP_CYC); // [RULE12]
            CMD_PAGE_PROG: op_cycles = hv ? TW'(PP_HV_CYCLES) : TW'(PP_CYCLES); // [RULE13]
            CMD_SECTOR_ERASE: op_cycles = hv ? TW'(SE_HV_CYCLES) : TW'(SE_CYCLES); // [RULE14]
            CMD_BLOCK32_ERASE: op_cycles = TW'(BE32_CYCLES); // [RULE15]
            CMD_BLOCK64_ERASE: op_cycles = TW'(BE64_CYCLES); // [RULE16]
            CMD_CHIP_ERASE: op_cycles = hv ? TW'(CE_HV_CYCLES) : TW'(CE_CYCLES); // [RULE17]
            default: op_cycles = '0;
        endcase
    endfunction : op_cycles

    // Recovery hold after a reset, chosen by what was interrupted
    function automatic logic [TW-1:0] rr_cycles(input logic [7:0] op);
        case (op)
            CMD_STATUS_WRITE: rr_cycles = TW'(RR_STW_CYCLES);
            CMD_BYTE_PROG, CMD_PAGE_PROG: rr_cycles = TW'(RR_PGM_CYCLES);
            CMD_SECTOR_ERASE, CMD_BLOCK32_ERASE,
            CMD_BLOCK64_ERASE, CMD_CHIP_ERASE: rr_cycles = TW'(RR_ERS_CYCLES);
            default: rr_cycles = TW'(RR_DEC_CYC);
        endcase
    endfunction : rr_cycles

    // Link: shift opcode bits in, the bit count saturating after the first byte
    always_comb begin
        bit_cnt_next = (bit_cnt_reg == 4'(OP_BITS)) ? bit_cnt_reg : bit_cnt_reg + 4'h1;
        shift_next = {shift_reg[6:0], si};
    end

    // Select high ends the frame; the link clock may stop right after it
    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_reg <= BIT_CNT_RST;
            shift_reg <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
        end
    end

    // Link: hold the opcode stable and flag it with a toggle for the core
    assign capture = (bit_cnt_reg == 4'(OP_BITS - 1));
    always_comb begin
        op_hold_next = capture ? {shift_reg[6:0], si} : op_hold_reg;
        op_tgl_next = capture ? ~op_tgl_reg : op_tgl_reg;
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_hold_reg <= CMD_NONE;
            op_tgl_reg <= 1'b0;
        end else begin
            op_hold_reg <= op_hold_next;
            op_tgl_reg <= op_tgl_next;
        end
    end

    // Pins and the link toggle enter the core domain
    level_sync #(.RST_VAL(1'b1)) cs_sync (.clk(core_clk), .rst_n(rst_n), .d(cs_n), .q(cs_s));
    level_sync #(.RST_VAL(1'b0)) hv_sync (.clk(core_clk), .rst_n(rst_n), .d(wp_high_voltage), .q(hv_s));
    level_sync #(.RST_VAL(1'b0)) tgl_sync (.clk(core_clk), .rst_n(rst_n), .d(op_tgl_reg), .q(tgl_s));

    // Select edges use an extra stage so a late opcode toggle still lands first
    assign cs_rise = cs_d1_reg & ~cs_d2_reg;
    assign cs_fall = ~cs_d1_reg & cs_d2_reg;
    assign cmd_go = cs_rise & pend_reg;

    // Command capture: a short frame leaves nothing pending and is ignored
    always_comb begin
        tgl_seen_next = tgl_s;
        pend_next = pend_reg;
        cmd_next = cmd_reg;
        if (tgl_s != tgl_seen_reg) begin
            pend_next = 1'b1;
            cmd_next = op_hold_reg;
        end else if (cs_fall || cs_rise) begin
            pend_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cs_d1_reg <= 1'b1;
            cs_d2_reg <= 1'b1;
            tgl_seen_reg <= 1'b0;
            pend_reg <= 1'b0;
            cmd_reg <= CMD_NONE;
        end else begin
            cs_d1_reg <= cs_s;
            cs_d2_reg <= cs_d1_reg;
            tgl_seen_reg <= tgl_seen_next;
            pend_reg <= pend_next;
            cmd_reg <= cmd_next;
        end
    end

    // Sequencer next state; each phase length is loaded into the timer
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        remain_next = remain_reg;
        t_load = 1'b0;
        t_val = '0;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_go) begin
                    if (cmd_reg == CMD_DEEP_PD) begin
                        state_next = ST_DPD_ENTER;
                        t_load = 1'b1;
                        t_val = TW'(DP_CYC); // [RULE1]
                    end else if (cmd_reg == CMD_SOFT_RESET) begin
                        state_next = ST_RST_RECOVER;
                        t_load = 1'b1;
                        t_val = rr_cycles(CMD_NONE);
                    end else if (op_cycles(cmd_reg, hv_s) != '0) begin
                        state_next = ST_BUSY;
                        kind_next = cmd_reg;
                        t_load = 1'b1;
                        t_val = op_cycles(cmd_reg, hv_s); // [RULE5] [RULE12] [RULE13] [RULE14]
                    end
                end
            end
            ST_BUSY: begin
                if (t_expire) begin
                    state_next = ST_IDLE; // [RULE19]
                end else if (cmd_go && cmd_reg == CMD_SOFT_RESET) begin
                    state_next = ST_RST_RECOVER;
                    t_load = 1'b1;
                    t_val = rr_cycles(kind_reg);
                end else if (cmd_go && cmd_reg == CMD_SUSPEND && kind_reg != CMD_STATUS_WRITE) begin
                    // No spacing check: program and erase suspends are taken whenever they come
                    state_next = ST_SUSPENDING; // [RULE11]
                    remain_next = t_count - TW'(1);
                    t_load = 1'b1;
                    t_val = TW'(SUSP_CYC); // [RULE7]
                end
            end
            ST_SUSPENDING: begin
                if (t_expire) begin
                    state_next = ST_SUSPENDED; // [RULE7]
                end
            end
            ST_SUSPENDED: begin
                if (cmd_go && cmd_reg == CMD_RESUME) begin
                    state_next = ST_BUSY;
                    t_load = 1'b1;
                    t_val = remain_reg;
                end else if (cmd_go && cmd_reg == CMD_SOFT_RESET) begin
                    state_next = ST_RST_RECOVER;
                    t_load = 1'b1;
                    t_val = rr_cycles(kind_reg);
                end
            end
            ST_DPD_ENTER: begin
                if (t_expire) begin
                    state_next = ST_DPD; // [RULE1]
                end
            end
            ST_DPD: begin
                // Only a select toggle wakes the device; opcodes are not decoded
                if (cs_fall) begin
                    state_next = ST_DPD_RECOVER;
                    t_load = 1'b1;
                    t_val = TW'(RDP_CYCLES); // [RULE4]
                end
            end
            ST_DPD_RECOVER: begin
                if (t_expire) begin
                    state_next = ST_IDLE; // [RULE4]
                end
            end
            ST_RST_RECOVER: begin
                if (t_expire) begin
                    state_next = ST_IDLE;
                    kind_next = CMD_NONE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next == ST_BUSY) || (state_next == ST_SUSPENDING) ||
                    (state_next == ST_DPD_RECOVER) || (state_next == ST_RST_RECOVER); // [RULE19]
        susp_next = (state_next == ST_SUSPENDED);
        dpd_next = (state_next == ST_DPD);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            kind_reg <= CMD_NONE;
            remain_reg <= '0;
            busy_flag <= 1'b0;
            suspended_flag <= 1'b0;
            dpd_flag <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            remain_reg <= remain_next;
            busy_flag <= busy_next;
            suspended_flag <= susp_next;
            dpd_flag <= dpd_next;
        end
    end

    // One timer serves every phase, so phases never overlap
    op_timer #(.WIDTH(TW)) phase_timer (
        .clk(core_clk),
        .rst_n(rst_n),
        .load(t_load),
        .load_val(t_val),
        .count(t_count),
        .expire(t_expire)
    );

    // Checking helpers: cycles spent in the current phase against its loaded length
    logic [TW-1:0] seg_age_reg;
    logic [TW-1:0] seg_len_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seg_age_reg <= '0;
            seg_len_reg <= '0;
        end else if (t_load) begin
            seg_age_reg <= TW'(1);
            seg_len_reg <= t_val;
        end else if (t_count > TW'(1)) begin
            // Stop at the last cycle so a finished phase rests at its own length
            seg_age_reg <= seg_age_reg + TW'(1);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_susp_req;
        state_reg == ST_BUSY && cmd_go && cmd_reg == CMD_SUSPEND && kind_reg != CMD_STATUS_WRITE && !t_expire;
    endsequence
    sequence s_susp_settle;
        (state_reg == ST_SUSPENDING && busy_flag) ##1 (state_reg == ST_SUSPENDING && busy_flag);
    endsequence

    AST_DPD_ENTRY: assert property ($rose(state_reg == ST_DPD_ENTER) |-> ##[1:1000] state_reg == ST_DPD) // [RULE1]
        else $error("deep power-down not reached in time");
    AST_RDP_HOLD: assert property (state_reg == ST_DPD_RECOVER && !t_expire && cmd_go
        |=> state_reg == ST_DPD_RECOVER && busy_flag) // [RULE4]
        else $error("command acted on during power-down recovery");
    AST_DPD_WAKE: assert property (state_reg == ST_DPD && cs_fall |=> state_reg == ST_DPD_RECOVER ##1 busy_flag) // [RULE4]
        else $error("select toggle did not start recovery");
    AST_SUSP_ACCEPT: assert property (s_susp_req |=> s_susp_settle) // [RULE11]
        else $error("suspend request not taken");
    AST_SUSP_DONE: assert property ($rose(state_reg == ST_SUSPENDED) |-> $past(state_reg) == ST_SUSPENDING
        && !busy_flag && seg_age_reg == TW'(SUSP_CYC)) // [RULE7]
        else $error("suspend did not end with busy low after its latency");
    AST_PHASE_BOUND: assert property (seg_age_reg <= seg_len_reg) // [RULE5] [RULE12] [RULE15] [RULE16] [RULE17]
        else $error("phase ran past its length");
    AST_BUSY_HOLD: assert property ((state_reg == ST_BUSY || state_reg == ST_SUSPENDING) |-> busy_flag) // [RULE19]
        else $error("busy flag low during operation");
    AST_BUSY_CLEAR: assert property ($fell(state_reg == ST_BUSY) && state_reg == ST_IDLE
        |-> !busy_flag && $past(t_expire)) // [RULE19]
        else $error("busy flag not cleared at completion");
endmodule : serial_flash_op_timing

// ### host_link_model.sv
// Host end of the serial link: frames opcodes and wakes the device from power-down
`timescale 1ns/10ps
module host_link_model (
    output logic cs_n,
    output logic si,
    output logic link_clk
);
    // Deselected with a still link clock from time zero
    initial begin
        cs_n = 1'b1;
        si = 1'b0;
        link_clk = 1'b0;
    end

    // One frame, MSB first; the link clock runs only inside the frame
    task automatic send_op(input logic [7:0] op);
        int i;
        cs_n = 1'b0;
        #5;
        for (i = 7; i >= 0; i--) begin
            si = op[i];
            #7.5 link_clk = 1'b1;
            #7.5 link_clk = 1'b0;
        end
        #15 cs_n = 1'b1;
        si = ~si; // Data line inverted after the frame, so never a stale level
    endtask : send_op

    // Select pulse, kept long since the sampler runs at 10 ns
    task automatic wake_pulse();
        cs_n = 1'b0;
        #40 cs_n = 1'b1;
    endtask : wake_pulse
endmodule : host_link_model

// ### tb_serial_flash_op_timing.sv
// Self-checking bench for the flash operation timing sequencer
`timescale 1ns/10ps
module tb_serial_flash_op_timing;
    import flash_timing_pkg::*;
    typedef struct packed {int lo; int hi;} span_t;
    localparam int RDP_N = 60, STW_N = 80, PP_N = 100, PPH_N = 70, SE_N = 120, SEH_N = 90;
    localparam int B32_N = 130, B64_N = 12000, CE_N = 150, CEH_N = 110, RRP_N = 50, RRE_N = 70, RRW_N = 40;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_high_voltage = 1'b0;
    logic cs_n, si, link_clk, busy_flag, suspended_flag, dpd_flag;
    int error_cnt = 0;
    int tests_run = 0;
    int run_len = 0;
    span_t notes[$];
    logic [7:0] ops[7] = '{CMD_STATUS_WRITE, CMD_BYTE_PROG, CMD_PAGE_PROG, CMD_SECTOR_ERASE,
                           CMD_BLOCK32_ERASE, CMD_BLOCK64_ERASE, CMD_CHIP_ERASE};
    logic [7:0] rst_ops[4] = '{CMD_NONE, CMD_SECTOR_ERASE, CMD_PAGE_PROG, CMD_STATUS_WRITE};
    int rst_len[4] = '{RR_DEC_CYC, RRE_N, RRP_N, RRW_N};

    // Core clock, 100 MHz
    always #5 core_clk = ~core_clk;

    host_link_model host (.cs_n(cs_n), .si(si), .link_clk(link_clk));

    serial_flash_op_timing #(.RDP_CYCLES(RDP_N), .STW_CYCLES(STW_N), .PP_CYCLES(PP_N), .PP_HV_CYCLES(PPH_N),
        .SE_CYCLES(SE_N), .SE_HV_CYCLES(SEH_N), .BE32_CYCLES(B32_N), .BE64_CYCLES(B64_N), .CE_CYCLES(CE_N),
        .CE_HV_CYCLES(CEH_N), .RR_PGM_CYCLES(RRP_N), .RR_ERS_CYCLES(RRE_N), .RR_STW_CYCLES(RRW_N)
    ) dut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .cs_n(cs_n), .si(si),
        .wp_high_voltage(wp_high_voltage), .busy_flag(busy_flag), .suspended_flag(suspended_flag),
        .dpd_flag(dpd_flag));

    task automatic bad(input string msg);
        error_cnt++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : bad

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic check_span(input int got, input span_t exp);
        tests_run++;
        if (got < exp.lo || got > exp.hi) bad($sformatf("busy run %0d not in %0d..%0d", got, exp.lo, exp.hi));
    endtask : check_span

    task automatic check_flag(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) bad({what, " flag differs"});
    endtask : check_flag

    // Bounded wait on the busy level; running out ends the run
    task automatic wait_busy(input logic v, input int bound);
        int i;
        for (i = 0; i < bound && busy_flag !== v; i++) @(negedge core_clk);
        if (busy_flag !== v) begin
            bad("busy wait ran out");
            print_verdict();
        end
    endtask : wait_busy

    function automatic int op_len(input logic [7:0] op, input logic hv);
        case (op)
            CMD_STATUS_WRITE: return STW_N;
            CMD_BYTE_PROG: return BP_CYC;
            CMD_PAGE_PROG: return hv ? PPH_N : PP_N;
            CMD_SECTOR_ERASE: return hv ? SEH_N : SE_N;
            CMD_BLOCK32_ERASE: return B32_N;
            CMD_BLOCK64_ERASE: return B64_N;
            default: return hv ? CEH_N : CE_N;
        endcase
    endfunction : op_len

    // Each finished busy run is matched to the oldest note
    always @(posedge core_clk) begin
        if (busy_flag === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len > 0) begin
            if (notes.size() == 0) bad("busy run without a note");
            else check_span(run_len, notes.pop_front());
            run_len <= 0;
        end
    end

    // Main sequence, inputs moved on the falling edge
    initial begin
        int n;
        void'($urandom(6));
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
        // Every timed operation, protect-pin level picked at random
        foreach (ops[k]) begin
            wp_high_voltage = 1'($urandom() % 2);
            repeat (6) @(negedge core_clk);
            n = op_len(ops[k], wp_high_voltage);
            notes.push_back('{n - 2, n + 2});
            host.send_op(ops[k]);
            wait_busy(1'b1, 30);
            wait_busy(1'b0, n + 30);
            repeat (8) @(negedge core_clk);
        end
        // Erase suspended, resumed, suspended again right after the minimum gap
        notes.push_back('{SUSP_CYC - 2, SUSP_CYC + 80});
        host.send_op(CMD_BLOCK64_ERASE);
        wait_busy(1'b1, 30);
        repeat (20) @(negedge core_clk);
        host.send_op(CMD_SUSPEND);
        wait_busy(1'b0, SUSP_CYC + 100);
        repeat (2) @(negedge core_clk);
        check_flag(suspended_flag, 1'b1, "suspended");
        notes.push_back('{SUSP_CYC, SUSP_CYC + 150});
        host.send_op(CMD_RESUME);
        wait_busy(1'b1, 30);
        repeat (40) @(negedge core_clk);
        host.send_op(CMD_SUSPEND);
        wait_busy(1'b0, SUSP_CYC + 150);
        repeat (2) @(negedge core_clk);
        check_flag(suspended_flag, 1'b1, "suspended");
        notes.push_back('{1, B64_N});
        host.send_op(CMD_RESUME);
        wait_busy(1'b1, 30);
        wait_busy(1'b0, B64_N + 30);
        repeat (8) @(negedge core_clk);
        check_flag(suspended_flag, 1'b0, "suspended");
        // Program suspended once, then left a long resume interval to run out
        n = op_len(CMD_PAGE_PROG, wp_high_voltage);
        notes.push_back('{SUSP_CYC - 2, SUSP_CYC + 80});
        notes.push_back('{1, n - 20});
        host.send_op(CMD_PAGE_PROG);
        wait_busy(1'b1, 30);
        repeat (20) @(negedge core_clk);
        host.send_op(CMD_SUSPEND);
        wait_busy(1'b0, SUSP_CYC + 100);
        repeat (2) @(negedge core_clk);
        check_flag(suspended_flag, 1'b1, "suspended");
        host.send_op(CMD_RESUME);
        wait_busy(1'b1, 30);
        wait_busy(1'b0, n + 30);
        repeat (8) @(negedge core_clk);
        check_flag(suspended_flag, 1'b0, "suspended");
        // A status write ignores a suspend request
        notes.push_back('{STW_N - 2, STW_N + 2});
        host.send_op(CMD_STATUS_WRITE);
        wait_busy(1'b1, 30);
        repeat (20) @(negedge core_clk);
        host.send_op(CMD_SUSPEND);
        wait_busy(1'b0, STW_N + 30);
        repeat (8) @(negedge core_clk);
        check_flag(suspended_flag, 1'b0, "suspended");
        // Deep power-down entry, host wait, release and recovery
        host.send_op(CMD_DEEP_PD);
        repeat (DP_CYC + 20) @(negedge core_clk);
        check_flag(dpd_flag, 1'b1, "power-down");
        repeat (3000) @(negedge core_clk);
        notes.push_back('{RDP_N - 2, RDP_N + 2});
        host.wake_pulse();
        wait_busy(1'b1, 30);
        check_flag(dpd_flag, 1'b0, "power-down");
        wait_busy(1'b0, RDP_N + 30);
        repeat (8) @(negedge core_clk);
        // Soft reset when idle and in mid-operation
        foreach (rst_ops[k]) begin
            notes.push_back('{rst_len[k] - 2, rst_len[k] + 60});
            if (rst_ops[k] !== CMD_NONE) begin
                host.send_op(rst_ops[k]);
                wait_busy(1'b1, 30);
                repeat (10) @(negedge core_clk);
            end
            host.send_op(CMD_SOFT_RESET);
            wait_busy(1'b1, 30);
            wait_busy(1'b0, rst_len[k] + 100);
            repeat (8) @(negedge core_clk);
        end
        if (notes.size() != 0) bad("busy run missing");
        print_verdict();
    end
endmodule : tb_serial_flash_op_timing
